// ===== verilog/mef_event_flags.sv
// Latched motion event register with masks, status forwarding and motion locks.
`timescale 1ns/100ps
module mef_event_flags #(
  parameter int ADDR_W = 7
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register access from the serial control interface.
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regWriteEn,
  input wire logic [31:0] regWriteData,
  input wire logic regReadEn,
  output logic [31:0] regReadData,
  output logic regReadValid,
  // Motion triggers from the ramp generator and comparators.
  input wire logic targetReached,
  input wire logic posCompReached,
  input wire logic speed_attained_event,
  input wire logic [1:0] speed_sign_state,
  input wire logic [1:0] rampState,
  input wire logic maxPhaseTrap,
  // Hardware stop switches and their enables.
  input wire logic left_stop_switch,
  input wire logic leftStopEn,
  input wire logic right_stop_switch,
  input wire logic rightStopEn,
  // Virtual limits: hit condition, limit rewrite pulse and enable.
  input wire logic softLeftLimitHit,
  input wire logic softLeftLimitWritten,
  input wire logic softLeftLimitEn,
  input wire logic softRightLimitHit,
  input wire logic softRightLimitWritten,
  input wire logic softRightLimitEn,
  // Homing, capture and step mode.
  input wire logic homeError,
  input wire logic positionCaptureDone,
  input wire logic fullstepActive,
  // Motor driver side.
  input wire logic driverDatagramSent,
  input wire logic stallStop,
  input wire logic [7:0] driverFlags,
  // Results.
  output logic [31:0] eventsOut,
  output logic [7:0] datagramStatus,
  output logic interrupt_output,
  output logic negMotionBlocked,
  output logic posMotionBlocked
);

  generate
    if (ADDR_W < 7) begin : g_bad_addr
      $error("mef_event_flags needs ADDR_W of at least seven");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [31:0] events_q; // Latched event bits.
  logic [31:0] events_d;
  logic [31:0] statusSel_q; // Events forwarded into datagram status bits.
  logic [31:0] clearProt_q; // Events that survive a readout.
  logic [31:0] intSel_q; // Events that drive the interrupt.
  logic [7:0] driver_status_select_q; // Driver flags that raise the driver event.
  logic [31:0] readData_q; // Read answer.
  logic readValid_q; // Read answer strobe.
  logic [7:0] status_q; // Packed datagram status.
  logic [7:0] status_d;
  logic irq_q; // Interrupt output.
  logic negBlock_q; // Negative motion refused.
  logic posBlock_q; // Positive motion refused.

  // Motion locks and the record of a limit rewrite since the last hit.
  logic leftStopLock_q;
  logic leftStopLock_d;
  logic rightStopLock_q;
  logic rightStopLock_d;
  logic softLeftLock_q;
  logic softLeftLock_d;
  logic softRightLock_q;
  logic softRightLock_d;
  logic softLeftNew_q;
  logic softLeftNew_d;
  logic softRightNew_q;
  logic softRightNew_d;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode.

  wire logic [6:0] addrLow = regAddr[6:0]; // Register address as documented.
  wire logic upperZero = (regAddr >> 7) == '0; // Higher address bits must be zero.
  wire logic hitDrv = upperZero && (addrLow == mef_pkg::REG_DRV_SETTINGS);
  wire logic hitStatusSel = upperZero && (addrLow == mef_pkg::REG_STATUS_SEL);
  wire logic hitClearProt = upperZero && (addrLow == mef_pkg::REG_CLEAR_PROT);
  wire logic hitIntSel = upperZero && (addrLow == mef_pkg::REG_INT_SEL);
  wire logic hitEvents = upperZero && (addrLow == mef_pkg::REG_EVENTS);

  // Read multiplexer; an unmapped address answers zero.
  wire logic [31:0] drvWord = {8'h00, driver_status_select_q, 16'h0000};
  wire logic [31:0] readMux = hitDrv ? drvWord :
                              hitStatusSel ? statusSel_q :
                              hitClearProt ? clearProt_q :
                              hitIntSel ? intSel_q :
                              hitEvents ? events_q : 32'h00000000;

  //////////////////////////////////////////////////////////////////////////////
  // Trigger conditions and their edges.

  mef_edge_if #(.WIDTH(32)) trig ();

  // Entering a state is the first cycle its code is seen.
  wire logic speedZero = speed_sign_state == mef_pkg::STATE_00;
  wire logic speedPos = speed_sign_state == mef_pkg::STATE_01;
  wire logic speedNeg = speed_sign_state == mef_pkg::STATE_10;
  wire logic rampConst = rampState == mef_pkg::STATE_00;
  wire logic rampRise = rampState == mef_pkg::STATE_01;
  wire logic rampFall = rampState == mef_pkg::STATE_10;

  // Only flags both reported and selected count for the driver event.
  wire logic driverHit = |(driverFlags & driver_status_select_q);

  // A switch only triggers while its stop function is enabled.
  wire logic leftStopCond = left_stop_switch && leftStopEn;
  wire logic rightStopCond = right_stop_switch && rightStopEn;
  wire logic softLeftCond = softLeftLimitHit && softLeftLimitEn;
  wire logic softRightCond = softRightLimitHit && softRightLimitEn;

  // Condition vector laid out at event positions; unlisted bits stay zero.
  always_comb begin
    trig.level = 32'h00000000;
    trig.level[mef_pkg::EV_TARGET] = targetReached;
    trig.level[mef_pkg::EV_POS_COMP] = posCompReached;
    trig.level[mef_pkg::EV_SPEED_ATTAINED] = speed_attained_event;
    trig.level[mef_pkg::EV_SPEED_ZERO] = speedZero;
    trig.level[mef_pkg::EV_SPEED_POS] = speedPos;
    trig.level[mef_pkg::EV_SPEED_NEG] = speedNeg;
    trig.level[mef_pkg::EV_RAMP_CONST] = rampConst;
    trig.level[mef_pkg::EV_RAMP_RISE] = rampRise;
    trig.level[mef_pkg::EV_RAMP_FALL] = rampFall;
    trig.level[mef_pkg::EV_MAX_PHASE] = maxPhaseTrap;
    trig.level[mef_pkg::EV_LEFT_STOP] = leftStopCond;
    trig.level[mef_pkg::EV_RIGHT_STOP] = rightStopCond;
    trig.level[mef_pkg::EV_SOFT_LEFT] = softLeftCond;
    trig.level[mef_pkg::EV_SOFT_RIGHT] = softRightCond;
    trig.level[mef_pkg::EV_HOME_ERROR] = homeError;
    trig.level[mef_pkg::EV_CAPTURE_DONE] = positionCaptureDone;
    trig.level[mef_pkg::EV_FULLSTEP] = fullstepActive;
    trig.level[mef_pkg::EV_DATAGRAM_SENT] = driverDatagramSent;
    trig.level[mef_pkg::EV_STALL_STOP] = stallStop;
    trig.level[mef_pkg::EV_DRIVER_FLAG] = driverHit;
  end

  // Edge detection lives in its own module so the history is kept in one place.
  mef_edge_detect #(.WIDTH(32)) u_edges (
    .clk(clk),
    .rst(rst),
    .edges(trig)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Event set and clear.

  // Reserved positions can never be set, so they read as zero.
  wire logic [31:0] setMask = trig.rise & mef_pkg::EVENTS_IMPL;
  // A read clears whatever is not protected; the value returned is pre-clear.
  wire logic readEvents = regReadEn && hitEvents;
  wire logic [31:0] readClear = readEvents ? ~clearProt_q : 32'h00000000;
  // Writing ones clears those bits as well, for software that polls by write.
  wire logic writeEvents = regWriteEn && hitEvents;
  wire logic [31:0] writeClear = writeEvents ? regWriteData : 32'h00000000;

  // Sticky hold, and a trigger in the clearing cycle wins over the clear.
  assign events_d = ((events_q & ~(readClear | writeClear)) | setMask)
                    & mef_pkg::EVENTS_IMPL;

  // The reset value carries the reset event itself.
  always_ff @(posedge clk) begin
    if (rst) begin
      events_q <= mef_pkg::EVENTS_RESET;
    end else begin
      events_q <= events_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mask and selection registers.

  always_ff @(posedge clk) begin
    if (rst) begin
      statusSel_q <= mef_pkg::STATUS_SEL_RESET;
      clearProt_q <= mef_pkg::CLEAR_PROT_RESET;
      intSel_q <= mef_pkg::INT_SEL_RESET;
      driver_status_select_q <= mef_pkg::DRV_SEL_RESET;
    end else if (regWriteEn) begin
      if (hitStatusSel) begin
        statusSel_q <= regWriteData;
      end
      if (hitClearProt) begin
        clearProt_q <= regWriteData;
      end
      if (hitIntSel) begin
        intSel_q <= regWriteData;
      end
      if (hitDrv) begin
        driver_status_select_q <= regWriteData[mef_pkg::DRV_SEL_LSB +: mef_pkg::DRV_SEL_W];
      end
    end
  end

  // Read answer appears one cycle after the strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      readData_q <= 32'h00000000;
      readValid_q <= 1'b0;
    end else begin
      readData_q <= regReadEn ? readMux : 32'h00000000;
      readValid_q <= regReadEn;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Datagram status packing and interrupt.

  // Selected events are packed from the LSB upward into the status byte;
  // selections beyond the eighth are dropped, which keeps the byte stable in width.
  always_comb begin
    int slot;
    slot = 0;
    status_d = 8'h00;
    for (int i = 0; i < 32; i++) begin
      if (statusSel_q[i] && (slot < mef_pkg::STATUS_W)) begin
        status_d[slot[2:0]] = events_d[i];
        slot = slot + 1;
      end
    end
  end

  wire logic irq_d = |(events_d & intSel_q);

  // Outputs follow the next event value so they line up with the register.
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Motion locks.

  // A lock holds until its event is gone and its release condition is met;
  // a fresh trigger always re-arms it.
  assign leftStopLock_d = setMask[mef_pkg::EV_LEFT_STOP] || (leftStopLock_q &&
      !(!events_q[mef_pkg::EV_LEFT_STOP] && (!left_stop_switch || !leftStopEn)));
  assign rightStopLock_d = setMask[mef_pkg::EV_RIGHT_STOP] || (rightStopLock_q &&
      !(!events_q[mef_pkg::EV_RIGHT_STOP] && (!right_stop_switch || !rightStopEn)));

  // A limit rewrite only counts if it comes in the same cycle as the hit that locked motion or after it.
  assign softLeftNew_d = softLeftLimitWritten ||
                         (softLeftNew_q && !setMask[mef_pkg::EV_SOFT_LEFT]);
  assign softRightNew_d = softRightLimitWritten ||
                          (softRightNew_q && !setMask[mef_pkg::EV_SOFT_RIGHT]);
  assign softLeftLock_d = setMask[mef_pkg::EV_SOFT_LEFT] || (softLeftLock_q &&
      !(!events_q[mef_pkg::EV_SOFT_LEFT] && (softLeftNew_q || !softLeftLimitEn)));
  assign softRightLock_d = setMask[mef_pkg::EV_SOFT_RIGHT] || (softRightLock_q &&
      !(!events_q[mef_pkg::EV_SOFT_RIGHT] && (softRightNew_q || !softRightLimitEn)));

  // Lock state and the direction refusals registered together.
  always_ff @(posedge clk) begin
    if (rst) begin
      leftStopLock_q <= 1'b0;
      rightStopLock_q <= 1'b0;
      softLeftLock_q <= 1'b0;
      softRightLock_q <= 1'b0;
      softLeftNew_q <= 1'b0;
      softRightNew_q <= 1'b0;
      negBlock_q <= 1'b0;
      posBlock_q <= 1'b0;
    end else begin
      leftStopLock_q <= leftStopLock_d;
      rightStopLock_q <= rightStopLock_d;
      softLeftLock_q <= softLeftLock_d;
      softRightLock_q <= softRightLock_d;
      softLeftNew_q <= softLeftNew_d;
      softRightNew_q <= softRightNew_d;
      negBlock_q <= leftStopLock_d || softLeftLock_d;
      posBlock_q <= rightStopLock_d || softRightLock_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output drive; every output is a flip-flop.

  assign regReadData = readData_q;
  assign regReadValid = readValid_q;
  assign eventsOut = events_q;
  assign datagramStatus = status_q;
  assign interrupt_output = irq_q;
  assign negMotionBlocked = negBlock_q;
  assign posMotionBlocked = posBlock_q;

endmodule : mef_event_flags

// ===== verilog/mef_pkg.sv
// Shared constants for the motion event flag register bank.
package mef_pkg;

  // Register addresses on the serial control interface.
  localparam logic [6:0] REG_DRV_SETTINGS = 7'h0a; // Driver settings, only the status select field.
  localparam logic [6:0] REG_STATUS_SEL = 7'h0b; // Selection for datagram status bits.
  localparam logic [6:0] REG_CLEAR_PROT = 7'h0c; // Clear protection mask.
  localparam logic [6:0] REG_INT_SEL = 7'h0d; // Interrupt selection mask.
  localparam logic [6:0] REG_EVENTS = 7'h0e; // Latched event register.

  // Event bit positions.
  localparam int EV_TARGET = 0;
  localparam int EV_POS_COMP = 1;
  localparam int EV_SPEED_ATTAINED = 2;
  localparam int EV_SPEED_ZERO = 3;
  localparam int EV_SPEED_POS = 4;
  localparam int EV_SPEED_NEG = 5;
  localparam int EV_RAMP_CONST = 6;
  localparam int EV_RAMP_RISE = 7;
  localparam int EV_RAMP_FALL = 8;
  localparam int EV_MAX_PHASE = 9;
  localparam int EV_LEFT_STOP = 11;
  localparam int EV_RIGHT_STOP = 12;
  localparam int EV_SOFT_LEFT = 13;
  localparam int EV_SOFT_RIGHT = 14;
  localparam int EV_HOME_ERROR = 15;
  localparam int EV_CAPTURE_DONE = 16;
  localparam int EV_FULLSTEP = 17;
  localparam int EV_DATAGRAM_SENT = 25;
  localparam int EV_STALL_STOP = 29;
  localparam int EV_DRIVER_FLAG = 30;
  localparam int EV_RESET = 31;

  // Field of the driver settings word that holds the driver status select.
  localparam int DRV_SEL_LSB = 16;
  localparam int DRV_SEL_W = 8;

  // Number of status bits carried with every datagram.
  localparam int STATUS_W = 8;

  // Two-bit state encodings shared by speed sign and ramp state.
  localparam logic [1:0] STATE_00 = 2'h0;
  localparam logic [1:0] STATE_01 = 2'h1;
  localparam logic [1:0] STATE_10 = 2'h2;

  // Reset values.
  localparam logic [31:0] EVENTS_RESET = 32'h80000000;
  localparam logic [31:0] STATUS_SEL_RESET = 32'h82029805;
  localparam logic [31:0] CLEAR_PROT_RESET = 32'h00000000;
  localparam logic [31:0] INT_SEL_RESET = 32'h00000000;
  localparam logic [7:0] DRV_SEL_RESET = 8'hfb;

  // Bits that exist; reserved bits always read as zero.
  localparam logic [31:0] EVENTS_IMPL = 32'he203fbff;

endpackage : mef_pkg

// ===== verilog/mef_edge_if.sv
// Carrier between the event bank and its rising edge detector.
`timescale 1ns/100ps
interface mef_edge_if #(
  parameter int WIDTH = 32
);
  logic [WIDTH-1:0] level; // Trigger conditions, one per event bit.
  logic [WIDTH-1:0] rise; // One-cycle pulse where a condition has just become true.

  // The bank drives conditions and takes pulses.
  modport bank (output level, input rise);
  // The detector takes conditions and drives pulses.
  modport detect (input level, output rise);
endinterface : mef_edge_if

// ===== verilog/mef_edge_detect.sv
// Rising edge detector for a vector of trigger conditions.
`timescale 1ns/100ps
module mef_edge_detect #(
  parameter int WIDTH = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Conditions in, pulses out.
  mef_edge_if.detect edges
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("mef_edge_detect needs WIDTH of at least one");
    end
  endgenerate

  logic [WIDTH-1:0] prevLevel_q; // Conditions as seen one cycle ago.

  // A condition already true when reset releases counts as a fresh trigger,
  // since the history starts cleared.
  always_ff @(posedge clk) begin
    if (rst) begin
      prevLevel_q <= '0;
    end else begin
      prevLevel_q <= edges.level;
    end
  end

  // Pulse for exactly the first cycle of each condition.
  assign edges.rise = edges.level & ~prevLevel_q;

endmodule : mef_edge_detect

// ===== dv/mef_host_model.sv
// Host model that reaches the event bank over its register port.
`timescale 1ns/100ps
module mef_host_model (
  // Clock.
  input wire logic clk,
  // Register port of the device.
  output logic [6:0] regAddr,
  output logic regWriteEn,
  output logic [31:0] regWriteData,
  output logic regReadEn,
  input wire logic [31:0] regReadData,
  input wire logic regReadValid
);
  // Idle bus: strobes low, address and data parked on junk.
  initial begin
    regAddr = 7'h55;
    regWriteEn = 1'b0;
    regWriteData = 32'ha5a5a5a5;
    regReadEn = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle write; released lines show the inverse so stale values never help.
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= d;
    regWriteEn <= 1'b1;
    @(posedge clk);
    regWriteEn <= 1'b0;
    regAddr <= ~a;
    regWriteData <= ~d;
  endtask : wr

  // One-cycle read; the answer is taken at the edge after the strobe is taken.
  task automatic rd(input logic [6:0] a, output logic [31:0] d, output logic v);
    @(posedge clk);
    regAddr <= a;
    regReadEn <= 1'b1;
    @(posedge clk);
    regReadEn <= 1'b0;
    regAddr <= ~a;
    @(posedge clk);
    d = regReadData;
    v = regReadValid;
  endtask : rd
endmodule : mef_host_model

// ===== dv/mef_event_flags_chk.sv
// Assertion checker for the motion event flag bank.
`timescale 1ns/100ps
module mef_event_flags_chk #(
  parameter int ADDR_W = 7
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regWriteEn,
  input wire logic [31:0] regWriteData,
  input wire logic regReadEn,
  input wire logic [31:0] regReadData,
  input wire logic regReadValid,
  // Stop triggers.
  input wire logic left_stop_switch,
  input wire logic leftStopEn,
  input wire logic softRightLimitHit,
  input wire logic softRightLimitEn,
  // Results.
  input wire logic [31:0] eventsOut,
  input wire logic [7:0] datagramStatus,
  input wire logic interrupt_output,
  input wire logic negMotionBlocked,
  input wire logic posMotionBlocked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Mask shadows rebuilt from bus writes, since the masks are not on the ports.
  logic [31:0] protQ;
  logic [31:0] intSelQ;
  wire protWr = regWriteEn && regAddr == ADDR_W'(mef_pkg::REG_CLEAR_PROT);
  wire intWr = regWriteEn && regAddr == ADDR_W'(mef_pkg::REG_INT_SEL);
  wire evRd = regReadEn && regAddr == ADDR_W'(mef_pkg::REG_EVENTS);
  wire [31:0] keptNow = protQ & eventsOut; // Set bits that a read must keep.

  // Shadows follow writes; reset values come from the package.
  always_ff @(posedge clk) begin
    if (rst) begin
      protQ <= mef_pkg::CLEAR_PROT_RESET;
      intSelQ <= mef_pkg::INT_SEL_RESET;
    end else begin
      protQ <= protWr ? regWriteData : protQ;
      intSelQ <= intWr ? regWriteData : intSelQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_RESERVED_ZERO: assert property (
    (eventsOut & ~mef_pkg::EVENTS_IMPL) == 32'h0)
    else $error("reserved event bit set");
  AST_STICKY: assert property (
    !regReadEn && !regWriteEn |=> (eventsOut & $past(eventsOut)) == $past(eventsOut))
    else $error("event bit dropped without clear");
  AST_PROT_KEEP: assert property (
    evRd |=> (eventsOut & $past(keptNow)) == $past(keptNow))
    else $error("protected event cleared by read");
  AST_READ_DATA: assert property (
    evRd |=> regReadValid && regReadData == $past(eventsOut))
    else $error("event read answer wrong");
  AST_INT_LEVEL: assert property (
    !$past(regWriteEn) |-> interrupt_output == |(eventsOut & intSelQ))
    else $error("interrupt level wrong");
  // The bench keeps the status selection at its reset pattern.
  AST_STATUS_PACK: assert property (
    !$past(rst) |-> datagramStatus == {eventsOut[31], eventsOut[25], eventsOut[17],
      eventsOut[15], eventsOut[12], eventsOut[11], eventsOut[2], eventsOut[0]})
    else $error("datagram status bits wrong");
  AST_LEFT_STOP: assert property (
    $rose(left_stop_switch && leftStopEn) |=> eventsOut[11] && negMotionBlocked)
    else $error("left stop not latched");
  AST_SOFT_RIGHT: assert property (
    $rose(softRightLimitHit && softRightLimitEn) |=> eventsOut[14] && posMotionBlocked)
    else $error("soft right limit not latched");
endmodule : mef_event_flags_chk

bind mef_event_flags mef_event_flags_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWriteEn(regWriteEn),
  .regWriteData(regWriteData), .regReadEn(regReadEn), .regReadData(regReadData),
  .regReadValid(regReadValid), .left_stop_switch(left_stop_switch), .leftStopEn(leftStopEn),
  .softRightLimitHit(softRightLimitHit), .softRightLimitEn(softRightLimitEn),
  .eventsOut(eventsOut), .datagramStatus(datagramStatus), .interrupt_output(interrupt_output),
  .negMotionBlocked(negMotionBlocked), .posMotionBlocked(posMotionBlocked)
);

// ===== dv/tb.sv
// Self-checking bench for the motion event flag bank.
`timescale 1ns/100ps
module tb;
  // Events that have a trigger of their own.
  localparam int EVL[18] = '{0, 1, 2, 4, 5, 7, 8, 9, 11, 12, 13, 14, 15, 16, 17, 25, 29, 30};
  logic clk;
  logic rst;
  logic [31:0] trig; // One trigger per event position.
  logic [3:0] en; // Stop and soft limit enables.
  logic [1:0] wrp; // Soft limit rewrite pulses.
  logic [7:0] flagVal; // Driver flags shown while bit 30 is triggered.
  int err_total;
  int checked;
  logic [6:0] regAddr;
  logic regWriteEn;
  logic [31:0] regWriteData;
  logic regReadEn;
  logic [31:0] regReadData;
  logic regReadValid;
  logic [31:0] eventsOut;
  logic [7:0] datagramStatus;
  logic interrupt_output;
  logic negMotionBlocked;
  logic posMotionBlocked;
  // Device inputs decoded from the stimulus registers.
  wire targetReached = trig[0];
  wire posCompReached = trig[1];
  wire speed_attained_event = trig[2];
  wire [1:0] speed_sign_state = {trig[5], trig[4]};
  wire [1:0] rampState = {trig[8], trig[7]};
  wire maxPhaseTrap = trig[9];
  wire left_stop_switch = trig[11];
  wire right_stop_switch = trig[12];
  wire softLeftLimitHit = trig[13];
  wire softRightLimitHit = trig[14];
  wire homeError = trig[15];
  wire positionCaptureDone = trig[16];
  wire fullstepActive = trig[17];
  wire driverDatagramSent = trig[25];
  wire stallStop = trig[29];
  wire [7:0] driverFlags = trig[30] ? flagVal : 8'h00;
  wire leftStopEn = en[0];
  wire rightStopEn = en[1];
  wire softLeftLimitEn = en[2];
  wire softRightLimitEn = en[3];
  wire softLeftLimitWritten = wrp[0];
  wire softRightLimitWritten = wrp[1];

  mef_event_flags u_mef_event_flags (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWriteEn(regWriteEn),
    .regWriteData(regWriteData), .regReadEn(regReadEn), .regReadData(regReadData),
    .regReadValid(regReadValid), .targetReached(targetReached),
    .posCompReached(posCompReached), .speed_attained_event(speed_attained_event),
    .speed_sign_state(speed_sign_state), .rampState(rampState), .maxPhaseTrap(maxPhaseTrap),
    .left_stop_switch(left_stop_switch), .leftStopEn(leftStopEn),
    .right_stop_switch(right_stop_switch), .rightStopEn(rightStopEn),
    .softLeftLimitHit(softLeftLimitHit), .softLeftLimitWritten(softLeftLimitWritten),
    .softLeftLimitEn(softLeftLimitEn), .softRightLimitHit(softRightLimitHit),
    .softRightLimitWritten(softRightLimitWritten), .softRightLimitEn(softRightLimitEn),
    .homeError(homeError), .positionCaptureDone(positionCaptureDone),
    .fullstepActive(fullstepActive), .driverDatagramSent(driverDatagramSent),
    .stallStop(stallStop), .driverFlags(driverFlags), .eventsOut(eventsOut),
    .datagramStatus(datagramStatus), .interrupt_output(interrupt_output),
    .negMotionBlocked(negMotionBlocked), .posMotionBlocked(posMotionBlocked)
  );
  mef_host_model u_mef_host_model (
    .clk(clk), .regAddr(regAddr), .regWriteEn(regWriteEn), .regWriteData(regWriteData),
    .regReadEn(regReadEn), .regReadData(regReadData), .regReadValid(regReadValid)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bench clock, 5 ns period.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Expected events: a state pulse also re-enters state 00 when it ends.
  function automatic logic [31:0] expEv(input int k);
    expEv = 32'h1 << k;
    if (k == 4 || k == 5) expEv = expEv | 32'h8;
    if (k == 7 || k == 8) expEv = expEv | 32'h40;
  endfunction : expEv

  // Packs selected events LSB upward into the eight status bits.
  function automatic logic [7:0] pk(input logic [31:0] ev);
    int n;
    n = 0;
    pk = 8'h00;
    for (int i = 0; i < 32; i++) begin
      if (mef_pkg::STATUS_SEL_RESET[i] && n < 8) begin
        pk[n] = ev[i];
        n++;
      end
    end
  endfunction : pk

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Reads a register and checks the answer strobe and the word.
  task automatic rdchk(input string what, input logic [6:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic v;
    u_mef_host_model.rd(a, d, v);
    check("read valid", 32'h1, {31'h0, v});
    check(what, exp, d);
  endtask : rdchk

  task automatic complete_run();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    repeat (8000) @(posedge clk);
    err_total++;
    complete_run();
  end

  // Main sequence.
  initial begin
    int k;
    logic [31:0] sel;
    logic [31:0] d;
    logic v;
    rst = 1'b1;
    trig = 32'h0;
    en = 4'hf;
    wrp = 2'b00;
    flagVal = 8'h01;
    err_total = 0;
    checked = 0;
    void'($urandom(66));
    tick(10);
    rst <= 1'b0;
    tick(1);
    // State bits may latch the state seen at release, so they are masked here.
    u_mef_host_model.rd(mef_pkg::REG_EVENTS, d, v);
    check("events at reset", mef_pkg::EVENTS_RESET, d & ~32'h1f8);
    rdchk("events cleared", mef_pkg::REG_EVENTS, 32'h0);
    rdchk("status select", mef_pkg::REG_STATUS_SEL, mef_pkg::STATUS_SEL_RESET);
    rdchk("driver select", mef_pkg::REG_DRV_SETTINGS, {8'h00, mef_pkg::DRV_SEL_RESET, 16'h0});
    rdchk("unmapped", 7'h3f, 32'h0);
    // Every trigger once in order, then random picks with random masks.
    for (int i = 0; i < 40; i++) begin
      k = (i < 18) ? EVL[i] : EVL[$urandom_range(17)];
      sel = $urandom();
      flagVal <= 8'($urandom()) | 8'h01;
      u_mef_host_model.wr(mef_pkg::REG_INT_SEL, sel);
      trig <= 32'h1 << k;
      tick(3);
      check("neg block", {31'h0, k == 11 || k == 13}, {31'h0, negMotionBlocked});
      check("pos block", {31'h0, k == 12 || k == 14}, {31'h0, posMotionBlocked});
      trig <= 32'h0;
      tick(2);
      check("events", expEv(k), eventsOut);
      check("status", {24'h0, pk(expEv(k))}, {24'h0, datagramStatus});
      check("interrupt", {31'h0, |(expEv(k) & sel)}, {31'h0, interrupt_output});
      rdchk("event read", mef_pkg::REG_EVENTS, expEv(k));
      check("after read", 32'h0, eventsOut);
      if ($urandom_range(1)) wrp <= 2'b11;
      else en[3:2] <= 2'b00;
      tick(1);
      wrp <= 2'b00;
      en <= 4'hf;
      tick(2);
      check("released", 32'h0, {30'h0, negMotionBlocked, posMotionBlocked});
    end
    // Unselected driver flags raise nothing; a cleared left stop holds while pressed.
    u_mef_host_model.wr(mef_pkg::REG_DRV_SETTINGS, 32'h00fe0000);
    flagVal <= 8'h01;
    trig <= 32'h40000800;
    tick(2);
    rdchk("stop held", mef_pkg::REG_EVENTS, 32'h00000800);
    tick(1);
    check("still blocked", 32'h1, {31'h0, negMotionBlocked});
    trig <= 32'h0;
    tick(3);
    check("unselected flag", 32'h0, eventsOut);
    // Protected bits survive a read; a written one clears them.
    u_mef_host_model.wr(mef_pkg::REG_CLEAR_PROT, 32'h00010001);
    trig <= 32'h00030001;
    tick(2);
    trig <= 32'h0;
    tick(2);
    rdchk("first read", mef_pkg::REG_EVENTS, 32'h00030001);
    rdchk("kept", mef_pkg::REG_EVENTS, 32'h00010001);
    u_mef_host_model.wr(mef_pkg::REG_EVENTS, 32'h00000001);
    rdchk("write clear", mef_pkg::REG_EVENTS, 32'h00010000);
    complete_run();
  end
endmodule : tb
